/* core/adc_regs_pkg.sv */
// constants, field layout and decode helpers for the channel, setup and
// diagnostic register bank; assumes six-bit register addresses
package adc_regs_pkg;

  // timing
  localparam int CORE_MHZ   = 125;
  localparam int IGNORE_NS  = 1000;
  localparam int IGNORE_CYC = (IGNORE_NS * CORE_MHZ + 999) / 1000;

  // register addresses
  localparam logic [5:0] STATUS_ADDR  = 6'h00;
  localparam logic [5:0] ID_ADDR      = 6'h05;
  localparam logic [5:0] ERR_ADDR     = 6'h06;
  localparam logic [5:0] ERR_EN_ADDR  = 6'h07;
  localparam logic [5:0] CLK_CNT_ADDR = 6'h08;
  localparam logic [5:0] CHAN_BASE    = 6'h09;
  localparam logic [5:0] CFG_BASE     = 6'h19;
  localparam logic [5:0] RATE_BASE    = 6'h20;
  localparam logic [5:0] RATE0_ADDR   = 6'h28;
  localparam logic [5:0] OFFS_BASE    = 6'h29;
  localparam logic [5:0] SPAN_BASE    = 6'h31;
  localparam logic [5:0] LAST_ADDR    = 6'h38;

  // counts and lengths
  localparam int         NUM_CHAN  = 16;
  localparam int         NUM_SETUP = 8;
  localparam logic [5:0] CMD_BITS  = 6'd8;
  localparam logic [5:0] LEN_8     = 6'd8;
  localparam logic [5:0] LEN_16    = 6'd16;
  localparam logic [5:0] LEN_24    = 6'd24;
  localparam logic [5:0] CNT_MAX   = 6'h3F;

  // reset values
  localparam logic [15:0] CHAN0_RST  = 16'h8001;
  localparam logic [15:0] CHAN_RST   = 16'h0001;
  localparam logic [15:0] CFG_RST    = 16'h0860;
  localparam logic [23:0] RATE_RST   = 24'h060180;
  localparam logic [23:0] OFFS_RST   = 24'h800000;
  localparam logic [23:0] ERR_EN_RST = 24'h000040;
  // arbitrary identity value
  localparam logic [7:0]  ID_VALUE   = 8'h5A;

  // field positions
  localparam int CMD_WEN_BIT  = 7;
  localparam int CMD_RD_BIT   = 6;
  localparam int CH_EN_BIT    = 15;
  localparam int CH_SETUP_LSB = 12;
  localparam int CH_POS_LSB   = 5;
  localparam int CH_NEG_LSB   = 0;
  localparam int CFG_BIP_BIT  = 11;
  localparam int CFG_REFP_BIT = 8;
  localparam int CFG_REFM_BIT = 7;
  localparam int CFG_POSITIVE_INPUT_SELECT_BIT = 6;
  localparam int CFG_NEGATIVE_INPUT_SELECT_BIT = 5;
  localparam int CFG_REF_LSB  = 3;
  localparam int CFG_GAIN_LSB = 0;
  localparam int RT_TYPE_LSB  = 21;
  localparam int RT_WORD_LSB  = 0;
  localparam int ERR_IGN_BIT  = 6;
  localparam int ERR_SCLK_BIT = 5;
  localparam int ERR_RD_BIT   = 4;
  localparam int ERR_WR_BIT   = 3;
  localparam int STAT_ERR_BIT = 6;

  typedef enum logic [1:0] {
    REF_INTERNAL, REF_EXT_PAIR1, REF_EXT_PAIR2, REF_SUPPLY_SPAN
  } ref_src_t;

  // data length of a register, zero where unmapped
  function automatic logic [5:0] reg_len(input logic [5:0] a);
    if (a == STATUS_ADDR || a == ID_ADDR || a == CLK_CNT_ADDR) begin
      return LEN_8;
    end else if (a == ERR_ADDR || a == ERR_EN_ADDR) begin
      return LEN_24;
    end else if (a >= CHAN_BASE && a < RATE_BASE + 6'd1) begin
      return LEN_16;
    end else if (a > RATE_BASE && a <= LAST_ADDR) begin
      return LEN_24;
    end
    return 6'd0;
  endfunction

  function automatic logic wr_ok(input logic [5:0] a);
    return a == ERR_EN_ADDR || (a >= CHAN_BASE && a <= LAST_ADDR);
  endfunction

  // slot of a register inside its group
  function automatic logic [3:0] slot(input logic [5:0] a);
    logic [5:0] d;
    d = 6'd0;
    if (a == RATE0_ADDR) d = 6'd0;
    else if (a >= SPAN_BASE) d = a - SPAN_BASE;
    else if (a >= OFFS_BASE) d = a - OFFS_BASE;
    else if (a > RATE_BASE) d = a - RATE_BASE;
    else if (a >= CFG_BASE) d = a - CFG_BASE;
    else if (a >= CHAN_BASE) d = a - CHAN_BASE;
    return d[3:0];
  endfunction

endpackage

/* core/adc_setup_regs.sv */
// channel, setup and diagnostic register bank with its serial port
// assumes core_clk at least eight times faster than spi_sclk, and cs_n
// high from power-up until the first frame
`timescale 1ns/100ps
`default_nettype none

module adc_setup_regs (
  // core clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // serial link
  input  wire logic                 spi_sclk,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  output logic                      dout,
  output logic                      dout_oe,
  // calibration and conversion events
  input  wire logic [23:0]          gain_trim,
  input  wire logic                 zero_cal_done,
  input  wire logic                 full_cal_done,
  input  wire logic [2:0]           cal_setup,
  input  wire logic [23:0]          cal_value,
  input  wire logic                 conv_done,
  // active channel and setup
  output logic [3:0]                seq_channel,
  output logic [4:0]                positive_input_select,
  output logic [4:0]                negative_input_select,
  output logic [2:0]                seq_setup,
  output logic                      seq_bipolar,
  output adc_regs_pkg::ref_src_t    seq_ref_sel,
  output logic [2:0]                amplifier_gain_select,
  output logic                      ref_pos_buffer_enable,
  output logic                      ref_neg_buffer_enable,
  output logic                      input_pos_buffer_enable,
  output logic                      input_neg_buffer_enable,
  output logic [2:0]                seq_filter_type,
  output logic [10:0]               rate_select_word,
  output logic [23:0]               seq_offset,
  output logic [23:0]               seq_span,
  // diagnostics
  output logic                      err_summary
);
  import adc_regs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // link side, clocked by spi_sclk
  logic        in_frame_q;
  logic [5:0]  bit_cnt_q;
  logic [5:0]  cnt_now;
  logic [6:0]  cmd_sh_q;
  logic [7:0]  cmd_q;
  logic [22:0] wr_sh_q;
  logic [23:0] wr_data_q;
  logic        cmd_seen_q;
  logic        wr_seen_q;
  logic        wr_last;
  logic [23:0] rd_sh_q;
  logic [5:0]  cmd_len;

  always_comb begin
    cnt_now = in_frame_q ? bit_cnt_q + 6'd1 : 6'd1;
    if (in_frame_q && bit_cnt_q == CNT_MAX) cnt_now = CNT_MAX;
    cmd_len = reg_len(cmd_q[5:0]);
  end

  always_ff @(posedge spi_sclk or posedge cs_n) begin
    if (cs_n) in_frame_q <= 1'b0;
    else      in_frame_q <= 1'b1;
  end

  always_ff @(posedge spi_sclk) begin
    bit_cnt_q <= cnt_now;
  end

  // command byte first, then data
  always_ff @(posedge spi_sclk) begin
    if (cnt_now < CMD_BITS) begin
      cmd_sh_q <= {cmd_sh_q[5:0], din};
    end else if (cnt_now == CMD_BITS) begin
      cmd_q     <= {cmd_sh_q, din};
    end
  end

  // last data bit of a write in this frame
  assign wr_last = cnt_now > CMD_BITS && !cmd_q[CMD_RD_BIT] &&
                   cmd_len != 6'd0 && cnt_now == CMD_BITS + cmd_len;

  // frame progress levels, cleared by cs_n so no stale state survives
  always_ff @(posedge spi_sclk or posedge cs_n) begin
    if (cs_n) begin
      cmd_seen_q <= 1'b0;
      wr_seen_q  <= 1'b0;
    end else begin
      if (cnt_now == CMD_BITS) cmd_seen_q <= 1'b1;
      if (wr_last)             wr_seen_q  <= 1'b1;
    end
  end

  always_ff @(posedge spi_sclk) begin
    if (cnt_now > CMD_BITS) begin
      wr_sh_q <= {wr_sh_q[21:0], din};
      if (wr_last) begin
        wr_data_q <= {wr_sh_q, din};
      end
    end
  end

  // read data out on the falling edge, msb first
  logic [23:0] rd_hold_q;

  always_ff @(negedge spi_sclk or posedge cs_n) begin
    if (cs_n) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else if (bit_cnt_q == CMD_BITS && cmd_q[CMD_RD_BIT] &&
                 !cmd_q[CMD_WEN_BIT]) begin
      dout    <= rd_hold_q[23];
      dout_oe <= 1'b1;
    end else if (bit_cnt_q > CMD_BITS) begin
      dout    <= rd_sh_q[22];
    end
  end

  always_ff @(negedge spi_sclk) begin
    if (bit_cnt_q == CMD_BITS) rd_sh_q <= rd_hold_q;
    else                       rd_sh_q <= {rd_sh_q[22:0], 1'b0};
  end

  //////////////////////////////////////////////////////////////////////////
  // crossings into core_clk
  logic [2:0] cs_sync_q;
  logic [2:0] cmd_sync_q;
  logic [2:0] wr_sync_q;
  logic       cs_rise;
  logic       cmd_evt;
  logic       wr_evt;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cs_sync_q  <= 3'h7;
      cmd_sync_q <= 3'h0;
      wr_sync_q  <= 3'h0;
    end else begin
      cs_sync_q  <= {cs_sync_q[1:0], cs_n};
      cmd_sync_q <= {cmd_sync_q[1:0], cmd_seen_q};
      wr_sync_q  <= {wr_sync_q[1:0], wr_seen_q};
    end
  end

  assign cs_rise = cs_sync_q[1] && !cs_sync_q[2];
  assign cmd_evt = cmd_sync_q[1] && !cmd_sync_q[2];
  assign wr_evt  = wr_sync_q[1] && !wr_sync_q[2];

  //////////////////////////////////////////////////////////////////////////
  // register storage
  logic [15:0] chan_q [NUM_CHAN];
  logic [15:0] cfg_q  [NUM_SETUP];
  logic [23:0] rate_q [NUM_SETUP];
  logic [23:0] offs_q [NUM_SETUP];
  logic [23:0] span_q [NUM_SETUP];
  logic [23:0] err_q;
  logic [23:0] err_en_q;
  logic [7:0]  clk_cnt_q;
  logic [5:0]  addr_q;
  logic        acc_rd_q;
  logic        acc_wen_q;
  logic [7:0]  ign_cnt_q;
  logic        ign_busy_q;
  logic [3:0]  cur_q;
  logic        wr_take;
  logic [3:0]  wslot;

  assign wslot   = slot(addr_q);
  assign wr_take = wr_evt && !ign_busy_q && !acc_rd_q && !acc_wen_q &&
                   wr_ok(addr_q);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_q    <= 6'h00;
      acc_rd_q  <= 1'b0;
      acc_wen_q <= 1'b0;
    end else if (cmd_evt) begin
      addr_q    <= cmd_q[5:0];
      acc_rd_q  <= cmd_q[CMD_RD_BIT];
      acc_wen_q <= cmd_q[CMD_WEN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (srst) begin
        chan_q[i] <= (i == 0) ? CHAN0_RST : CHAN_RST;
      end else if (wr_take && addr_q >= CHAN_BASE && addr_q < CFG_BASE &&
                   wslot == 4'(i)) begin
        chan_q[i] <= wr_data_q[15:0] & 16'hF3FF;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int k = 0; k < NUM_SETUP; k++) begin
      if (srst) begin
        cfg_q[k]  <= CFG_RST;
        rate_q[k] <= RATE_RST;
      end else if (wr_take && wslot == 4'(k)) begin
        if (addr_q >= CFG_BASE && addr_q <= RATE_BASE) begin
          cfg_q[k] <= wr_data_q[15:0];
        end
        if ((addr_q > RATE_BASE && addr_q < OFFS_BASE)) begin
          rate_q[k] <= wr_data_q;
        end
      end
    end
  end

  // calibration results take priority over a host write
  always_ff @(posedge core_clk) begin
    for (int k = 0; k < NUM_SETUP; k++) begin
      if (srst) begin
        offs_q[k] <= OFFS_RST;
        span_q[k] <= gain_trim;
      end else begin
        if (zero_cal_done && cal_setup == 3'(k)) begin
          offs_q[k] <= cal_value;
        end else if (wr_take && addr_q >= OFFS_BASE &&
                     addr_q < SPAN_BASE && wslot == 4'(k)) begin
          offs_q[k] <= wr_data_q;
        end
        if (full_cal_done && cal_setup == 3'(k)) begin
          span_q[k] <= cal_value;
        end else if (wr_take && addr_q >= SPAN_BASE &&
                     wslot == 4'(k)) begin
          span_q[k] <= wr_data_q;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      err_en_q <= ERR_EN_RST;
    end else if (wr_take && addr_q == ERR_EN_ADDR) begin
      err_en_q <= wr_data_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // diagnostics
  logic [5:0]  frame_len;
  logic [23:0] err_set;

  assign frame_len = CMD_BITS + reg_len(cmd_q[5:0]);

  always_comb begin
    err_set = 24'h000000;
    err_set[ERR_IGN_BIT] = wr_evt && ign_busy_q;
    err_set[ERR_WR_BIT]  = cmd_evt && !cmd_q[CMD_RD_BIT] &&
                           !cmd_q[CMD_WEN_BIT] && !wr_ok(cmd_q[5:0]);
    err_set[ERR_RD_BIT]  = cmd_evt && cmd_q[CMD_RD_BIT] &&
                           !cmd_q[CMD_WEN_BIT] &&
                           reg_len(cmd_q[5:0]) == 6'd0;
    err_set[ERR_SCLK_BIT] = cs_rise && bit_cnt_q != frame_len;
  end

  // reading the flags clears them; a new event in that cycle survives
  always_ff @(posedge core_clk) begin
    if (srst) begin
      err_q <= 24'h000000;
    end else begin
      err_q <= ((cmd_evt && cmd_q[CMD_RD_BIT] && cmd_q[5:0] == ERR_ADDR) ?
                24'h000000 : err_q) | (err_set & err_en_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) err_summary <= 1'b0;
    else      err_summary <= |(err_q & err_en_q);
  end

  // host writes refused while this window runs out after reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ign_cnt_q  <= 8'(IGNORE_CYC);
      ign_busy_q <= 1'b1;
    end else begin
      if (ign_cnt_q != 8'h00) ign_cnt_q <= ign_cnt_q - 8'h01;
      ign_busy_q <= ign_cnt_q > 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) clk_cnt_q <= 8'h00;
    else      clk_cnt_q <= clk_cnt_q + 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////
  // read path, captured when a command arrives
  logic [23:0] rd_word;
  logic [5:0]  rd_addr;
  logic [5:0]  rd_len;
  logic [3:0]  rslot;

  assign rd_addr = cmd_q[5:0];
  assign rd_len  = reg_len(rd_addr);
  assign rslot   = slot(rd_addr);

  always_comb begin
    rd_word = 24'h000000;
    if (rd_addr == STATUS_ADDR) begin
      rd_word[STAT_ERR_BIT] = err_summary;
      rd_word[3:0]          = cur_q;
    end else if (rd_addr == ID_ADDR) begin
      rd_word[7:0] = ID_VALUE;
    end else if (rd_addr == ERR_ADDR) begin
      rd_word = err_q;
    end else if (rd_addr == ERR_EN_ADDR) begin
      rd_word = err_en_q;
    end else if (rd_addr == CLK_CNT_ADDR) begin
      rd_word[7:0] = clk_cnt_q;
    end else if (rd_len != 6'd0 && rd_addr < CFG_BASE) begin
      rd_word[15:0] = chan_q[rslot];
    end else if (rd_len != 6'd0 && rd_addr <= RATE_BASE) begin
      rd_word[15:0] = cfg_q[rslot[2:0]];
    end else if (rd_len != 6'd0 && rd_addr < OFFS_BASE) begin
      rd_word = rate_q[rslot[2:0]];
    end else if (rd_len != 6'd0 && rd_addr < SPAN_BASE) begin
      rd_word = offs_q[rslot[2:0]];
    end else if (rd_len != 6'd0) begin
      rd_word = span_q[rslot[2:0]];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst)         rd_hold_q <= 24'h000000;
    else if (cmd_evt) rd_hold_q <= rd_word << (LEN_24 - rd_len);
  end

  //////////////////////////////////////////////////////////////////////////
  // channel sequencer
  logic [15:0] chan_en;

  function automatic logic [3:0] next_chan(input logic [3:0]  cur,
                                           input logic [15:0] en);
    logic [3:0] n;
    logic       hit;
    n   = cur;
    hit = 1'b0;
    for (int i = 1; i <= NUM_CHAN; i++) begin
      if (!hit && en[4'(cur + 4'(i))]) begin
        n   = 4'(cur + 4'(i));
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) chan_en[i] = chan_q[i][CH_EN_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (srst)           cur_q <= 4'h0;
    else if (conv_done) cur_q <= next_chan(cur_q, chan_en);
  end

  //////////////////////////////////////////////////////////////////////////
  // active channel and setup outputs
  logic [2:0]  sel;
  logic [15:0] cfg_a;

  assign sel   = chan_q[cur_q][CH_SETUP_LSB +: 3];
  assign cfg_a = cfg_q[sel];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      seq_channel           <= 4'h0;
      positive_input_select <= CHAN0_RST[CH_POS_LSB +: 5];
      negative_input_select <= CHAN0_RST[CH_NEG_LSB +: 5];
      seq_setup             <= 3'h0;
    end else begin
      seq_channel           <= cur_q;
      positive_input_select <= chan_q[cur_q][CH_POS_LSB +: 5];
      negative_input_select <= chan_q[cur_q][CH_NEG_LSB +: 5];
      seq_setup             <= sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      seq_bipolar             <= 1'b0;
      seq_ref_sel             <= REF_INTERNAL;
      amplifier_gain_select   <= 3'h0;
      ref_pos_buffer_enable   <= 1'b0;
      ref_neg_buffer_enable   <= 1'b0;
      input_pos_buffer_enable <= 1'b0;
      input_neg_buffer_enable <= 1'b0;
    end else begin
      seq_bipolar             <= cfg_a[CFG_BIP_BIT];
      seq_ref_sel             <= ref_src_t'(cfg_a[CFG_REF_LSB +: 2]);
      amplifier_gain_select   <= cfg_a[CFG_GAIN_LSB +: 3];
      ref_pos_buffer_enable   <= cfg_a[CFG_REFP_BIT];
      ref_neg_buffer_enable   <= cfg_a[CFG_REFM_BIT];
      input_pos_buffer_enable <= cfg_a[CFG_POSITIVE_INPUT_SELECT_BIT];
      input_neg_buffer_enable <= cfg_a[CFG_NEGATIVE_INPUT_SELECT_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      seq_filter_type  <= 3'h0;
      rate_select_word <= 11'h000;
      seq_offset       <= OFFS_RST;
      seq_span         <= 24'h000000;
    end else begin
      seq_filter_type  <= rate_q[sel][RT_TYPE_LSB +: 3];
      rate_select_word <= rate_q[sel][RT_WORD_LSB +: 11];
      seq_offset       <= offs_q[sel];
      seq_span         <= span_q[sel];
    end
  end

endmodule

`default_nettype wire

/* sim/adc_setup_regs_sva.sv */
// assertions on the channel, setup and diagnostic register bank
// assumes binding to adc_setup_regs and sight of its ports only
`timescale 1ns/100ps
`default_nettype none

module adc_setup_regs_sva (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   srst,
  // link
  input wire logic                   spi_sclk,
  input wire logic                   cs_n,
  input wire logic                   dout,
  input wire logic                   dout_oe,
  // events
  input wire logic [23:0]            gain_trim,
  input wire logic                   zero_cal_done,
  input wire logic                   full_cal_done,
  input wire logic [2:0]             cal_setup,
  input wire logic [23:0]            cal_value,
  input wire logic                   conv_done,
  // active channel, setup and diagnostics
  input wire logic [3:0]             seq_channel,
  input wire logic [4:0]             positive_input_select,
  input wire logic [4:0]             negative_input_select,
  input wire logic [2:0]             seq_setup,
  input wire logic                   seq_bipolar,
  input wire adc_regs_pkg::ref_src_t seq_ref_sel,
  input wire logic [2:0]             amplifier_gain_select,
  input wire logic [10:0]            rate_select_word,
  input wire logic [23:0]            seq_offset,
  input wire logic [23:0]            seq_span,
  input wire logic                   err_summary
);
  import adc_regs_pkg::*;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////
  property p_link_idle;
    cs_n |-> !dout_oe && !dout;
  endproperty
  property p_oe_edge;
    $rose(dout_oe) |-> !spi_sclk && !cs_n;
  endproperty
  property p_dout_edge;
    $changed(dout) && !cs_n |-> !spi_sclk;
  endproperty
  property p_seq_rst;
    $fell(srst) |-> seq_channel == 4'h0 && seq_setup == 3'h0 &&
      positive_input_select == 5'h0 && negative_input_select == 5'h1;
  endproperty
  property p_setup_rst;
    $fell(srst) |=> seq_bipolar && seq_ref_sel == REF_INTERNAL &&
      amplifier_gain_select == 3'h0 && rate_select_word == 11'h180 &&
      seq_offset == 24'h800000 && seq_span == gain_trim;
  endproperty
  property p_err_rst;
    $fell(srst) |-> !err_summary;
  endproperty
  property p_seq_step;
    $changed(seq_channel) && !$past(srst) && !$past(srst, 2)
      |-> $past(conv_done, 2);
  endproperty
  property p_zero_cal;
    zero_cal_done && !full_cal_done && cal_setup == seq_setup &&
      !conv_done && !$past(conv_done)
      |-> ##2 seq_offset == $past(cal_value, 2);
  endproperty
  property p_full_cal;
    full_cal_done && !zero_cal_done && cal_setup == seq_setup &&
      !conv_done && !$past(conv_done)
      |-> ##2 seq_span == $past(cal_value, 2);
  endproperty

  ////////////////////////////////////////////////////////////////////////
  a_link_idle: assert property (p_link_idle)
    else $error("dout active outside a frame");
  a_oe_edge: assert property (p_oe_edge)
    else $error("dout enable rose off the drive edge");
  a_dout_edge: assert property (p_dout_edge)
    else $error("dout moved while link clock high");
  a_seq_rst: assert property (p_seq_rst)
    else $error("channel fields wrong after reset");
  a_setup_rst: assert property (p_setup_rst)
    else $error("setup fields wrong after reset");
  a_err_rst: assert property (p_err_rst)
    else $error("error summary set after reset");
  a_seq_step: assert property (p_seq_step)
    else $error("channel moved without conversion done");
  a_zero_cal: assert property (p_zero_cal)
    else $error("offset not loaded by calibration");
  a_full_cal: assert property (p_full_cal)
    else $error("span not loaded by calibration");

  c_read: cover property ($rose(dout_oe));
  c_step: cover property ($changed(seq_channel));
  c_err: cover property ($rose(err_summary));
endmodule

bind adc_setup_regs adc_setup_regs_sva chk (
  .core_clk, .srst, .spi_sclk, .cs_n, .dout, .dout_oe, .gain_trim,
  .zero_cal_done, .full_cal_done, .cal_setup, .cal_value, .conv_done,
  .seq_channel, .positive_input_select, .negative_input_select,
  .seq_setup, .seq_bipolar, .seq_ref_sel, .amplifier_gain_select,
  .rate_select_word, .seq_offset, .seq_span, .err_summary
);
`default_nettype wire

/* sim/spi_host_model.sv */
// serial host that frames one command and its data, mode 3
// assumes 125 ns link clock period, idle only between frames
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
  // link
  output logic     spi_sclk,
  output logic     cs_n,
  output logic     din,
  input wire logic dout
);
  initial begin
    spi_sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
  end

  // n data bits follow the command, msb first
  task automatic xfer(input logic [7:0] cmd, input int n,
                      input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] sh;
    sh = ({24'h0, cmd} << n) | {8'h0, wd};
    rd = 24'h0;
    #3.3 cs_n = 1'b0;
    #40;
    for (int k = 7 + n; k >= 0; k--) begin
      spi_sclk = 1'b0;
      din = sh[k];
      #62.5 spi_sclk = 1'b1;
      rd = {rd[22:0], dout};
      #62.5;
    end
    cs_n = 1'b1;
    din = ~din;
    rd = rd & ~(24'hFFFFFF << n);
    #100;
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the register bank behind its serial port
// assumes the serial host model and the bound checker
`timescale 1ns/100ps
`default_nettype none

module tb;
  import adc_regs_pkg::*;

  logic        core_clk, srst, spi_sclk, cs_n, din, dout, dout_oe;
  logic        zero_cal_done, full_cal_done, conv_done, err_summary;
  logic        seq_bipolar, ref_pos_buffer_enable, ref_neg_buffer_enable;
  logic        input_pos_buffer_enable, input_neg_buffer_enable;
  logic [2:0]  cal_setup, seq_setup, amplifier_gain_select;
  logic [2:0]  seq_filter_type;
  logic [3:0]  seq_channel;
  logic [4:0]  positive_input_select, negative_input_select;
  logic [10:0] rate_select_word;
  logic [23:0] gain_trim, cal_value, seq_offset, seq_span;
  ref_src_t    seq_ref_sel;
  int          miscompares, n_compared;

  adc_setup_regs DUT (.*);
  spi_host_model host (.spi_sclk, .cs_n, .din, .dout);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input int n, input logic [23:0] d);
    logic [23:0] r;
    host.xfer({2'b00, a}, n, d, r);
    settle(6);
  endtask
  task automatic rd(input logic [5:0] a, input int n, input logic [23:0] e);
    logic [23:0] r;
    host.xfer({2'b01, a}, n, 24'h0, r);
    cmp(r, e);
  endtask
  task automatic conv();
    @(posedge core_clk) conv_done <= 1'b1;
    @(posedge core_clk) conv_done <= 1'b0;
    settle(3);
  endtask
  task automatic cal(input logic full, input logic [23:0] v);
    @(posedge core_clk);
    cal_setup <= 3'h1;
    cal_value <= v;
    zero_cal_done <= ~full;
    full_cal_done <= full;
    @(posedge core_clk);
    zero_cal_done <= 1'b0;
    full_cal_done <= 1'b0;
    settle(3);
  endtask
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    miscompares++;
    test_done();
  end

  initial begin
    logic [23:0] r;
    logic [15:0] v;
    logic [2:0]  g;
    srst = 1'b1;
    conv_done = 1'b0;
    zero_cal_done = 1'b0;
    full_cal_done = 1'b0;
    cal_setup = 3'h0;
    cal_value = 24'h0;
    gain_trim = 24'h5C3A71;
    settle(6);
    srst <= 1'b0;
    rd(ID_ADDR, 8, {16'h0, ID_VALUE});
    // write lands just after a second reset
    @(posedge core_clk) srst <= 1'b1;
    settle(2);
    fork
      host.xfer(8'h0A, 16, 24'h008021, r);
      begin
        settle(340);
        srst <= 1'b0;
      end
    join
    rd(STATUS_ADDR, 8, 24'h40);
    rd(ERR_ADDR, 24, 24'h000040);
    rd(6'h0A, 16, 24'h0001);
    rd(ERR_ADDR, 24, 24'h0);
    rd(CHAN_BASE, 16, 24'h8001);
    rd(CFG_BASE, 16, 24'h0860);
    rd(RATE0_ADDR, 24, 24'h060180);
    rd(OFFS_BASE, 24, 24'h800000);
    rd(SPAN_BASE, 24, gain_trim);
    rd(ERR_EN_ADDR, 24, 24'h000040);
    // read, write and clock count checks
    wr(ERR_EN_ADDR, 24, 24'h000078);
    host.xfer(8'h42, 8, 24'h0, r);
    cmp(r, 24'h0);
    wr(ID_ADDR, 8, 24'hFF);
    host.xfer(8'h45, 16, 24'h0, r);
    cmp(err_summary, 1'b1);
    rd(ERR_ADDR, 24, 24'h000038);
    wr(ERR_EN_ADDR, 24, 24'h0);
    wr(ID_ADDR, 8, 24'hFF);
    rd(ERR_ADDR, 24, 24'h0);
    // sequencer and setup one
    wr(6'h0C, 16, 24'h9043);
    wr(6'h18, 16, 24'h8085);
    wr(6'h21, 24, 24'hA007FF);
    wr(6'h2A, 24, 24'h123456);
    rd(6'h2A, 24, 24'h123456);
    conv();
    cmp(seq_channel, 4'h3);
    cmp({positive_input_select, negative_input_select, seq_setup},
        {5'h2, 5'h3, 3'h1});
    cmp({seq_filter_type, rate_select_word}, {3'h5, 11'h7FF});
    cmp(seq_offset, 24'h123456);
    for (int i = 0; i < 8; i++) begin
      g = i[2:0];
      v = {4'h0, g[0], 2'b00, g[1], g[2], g[0], ~g[0], g[1:0], g};
      wr(6'h1A, 16, {8'h0, v});
      cmp({seq_bipolar, ref_pos_buffer_enable, ref_neg_buffer_enable,
           input_pos_buffer_enable, input_neg_buffer_enable,
           seq_ref_sel, amplifier_gain_select}, {v[11], v[8:0]});
    end
    cal(1'b0, 24'h0ABCDE);
    cmp(seq_offset, 24'h0ABCDE);
    cal(1'b1, 24'h4F0F0F);
    cmp(seq_span, 24'h4F0F0F);
    rd(6'h32, 24, 24'h4F0F0F);
    conv();
    cmp(seq_channel, 4'hF);
    conv();
    cmp(seq_channel, 4'h0);
    test_done();
  end
endmodule
`default_nettype wire
